// file: logic/rcoc_pkg.sv
package rcoc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // configuration register layout
  localparam int unsigned CFG_W          = 12;
  localparam int unsigned MODE_LSB       = 0;
  localparam int unsigned WIRING_BIT     = 2;
  localparam int unsigned SWING_BIT      = 3;
  localparam int unsigned LOCK_LSB       = 2;
  localparam int unsigned AUX_LOCK_LSB   = 10;
  localparam logic [11:0] CFG_RESET      = 12'h000;
  localparam logic [11:0] AUX_RESET      = 12'h000;

  // read clock operating modes
  typedef enum logic [1:0] {
    RCOC_MODE_OFF   = 2'b00,
    RCOC_MODE_READ  = 2'b01,
    RCOC_MODE_BEGIN = 2'b10,
    RCOC_MODE_ON    = 2'b11
  } rcoc_mode_e;

  // commands carried over the link
  typedef enum logic [3:0] {
    RCOC_CMD_NOP      = 4'h0,
    RCOC_CMD_CFG_WR   = 4'h1,
    RCOC_CMD_AUX_WR   = 4'h2,
    RCOC_CMD_READ     = 4'h3,
    RCOC_CMD_BEGIN    = 4'h4,
    RCOC_CMD_HALT     = 4'h5,
    RCOC_CMD_READ_AP  = 4'h6,
    RCOC_CMD_READ_INT = 4'h7,
    RCOC_CMD_READ_TRN = 4'h8,
    RCOC_CMD_READ_ERR = 4'h9
  } rcoc_cmd_e;

  ////////////////////////////////////////////////////////////////////////////
  // timing, in ns and in 8 ns clock cycles (least times round up)
  localparam int unsigned CLK_PERIOD_PS     = 8000;
  localparam int unsigned SETTLE_NS         = 40;
  localparam int unsigned HALT_WAIT_NS      = 24;
  localparam int unsigned BEGIN_HALT_WAIT_NS = 24;
  localparam int unsigned SETTLE_CYC =
    (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned HALT_WAIT_CYC =
    (HALT_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BEGIN_HALT_WAIT_CYC =
    (BEGIN_HALT_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CMD_GAP_CYC       = 6;
  localparam int unsigned ON_START_CYC      = 2;
  localparam int unsigned CNT_W             = 8;

  // true for every read-type command
  function automatic logic is_read(input logic [3:0] c);
    is_read = (c == RCOC_CMD_READ) || (c == RCOC_CMD_READ_AP) ||
              (c == RCOC_CMD_READ_INT) || (c == RCOC_CMD_READ_TRN) ||
              (c == RCOC_CMD_READ_ERR);
  endfunction

endpackage

// file: logic/rcoc_link_if.sv
`timescale 1ns/1ps
interface rcoc_link_if #(
  parameter int unsigned DW = 8
);
  // host to device: command code, data and event toggle
  logic [3:0]    cmd_code;
  logic [11:0]   cmd_data;
  logic          cmd_tgl;
  // device to host: read clock pins and data lanes
  logic          read_clock_true;
  logic          read_clock_true_oe_b;
  logic          read_clock_comp;
  logic          read_clock_comp_oe_b;
  logic          read_clock_half_swing;
  logic [DW-1:0] dq;

  modport device (
    input  cmd_code, cmd_data, cmd_tgl,
    output read_clock_true, read_clock_true_oe_b, read_clock_comp,
    output read_clock_comp_oe_b, read_clock_half_swing, dq
  );
  modport host (
    output cmd_code, cmd_data, cmd_tgl,
    input  read_clock_true, read_clock_true_oe_b, read_clock_comp,
    input  read_clock_comp_oe_b, read_clock_half_swing, dq
  );
endinterface

// file: logic/rcoc_device.sv
`timescale 1ns/1ps
// Contract
// - one read clock, true and complement pins
// - clock edges coincide with data symbol changes
// - wiring bit picks differential or single-ended
// - three-level: swing bit picks full/half
// - two-level: swing bit ignored, full swing
// - disabled clock leaves both pins undriven
// - mode field: 00 off default, 11 on
// - always-on toggles freely at write-clock rate
// - two start/stop modes differ by start command
// - host disables and settles before mode change
// - host keeps locked bits during always-on
// - read-start mode: halt, wait, then reconfigure
// - begin-start mode: halt, wait, then reconfigure
// - mode 01: reads start clock, no begin
// - mode 10: only begin starts clock
// - halt stops clock synchronously, then undriven
// - always-on starts toggling within settle time
module rcoc_device #(
  parameter int unsigned DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          three_level_i,
  input  wire logic [DW-1:0] rd_data_i,
  output logic               rd_ready_o,
  output logic [1:0]         mode_o,
  output logic               running_o,
  output logic [11:0]        aux_o,
  rcoc_link_if.device        link
);

  ////////////////////////////////////////////////////////////////////////////
  // clock output states
  typedef enum logic [1:0] {
    RCOC_ST_OFF  = 2'b00,
    RCOC_ST_IDLE = 2'b01,
    RCOC_ST_RUN  = 2'b10,
    RCOC_ST_STOP = 2'b11
  } rcoc_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // link inputs come from the host's domain: two flops before any logic
  logic        tgl_s1_reg;
  logic        tgl_s2_reg;
  logic        tgl_s3_reg;
  logic [3:0]  code_s1_reg;
  logic [3:0]  code_s2_reg;
  logic [11:0] data_s1_reg;
  logic [11:0] data_s2_reg;
  logic        cmd_evt;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tgl_s1_reg  <= 1'b0;
      tgl_s2_reg  <= 1'b0;
      tgl_s3_reg  <= 1'b0;
      code_s1_reg <= 4'h0;
      code_s2_reg <= 4'h0;
      data_s1_reg <= 12'h000;
      data_s2_reg <= 12'h000;
    end else begin
      tgl_s1_reg  <= link.cmd_tgl;
      tgl_s2_reg  <= tgl_s1_reg;
      tgl_s3_reg  <= tgl_s2_reg;
      code_s1_reg <= link.cmd_code;
      code_s2_reg <= code_s1_reg;
      data_s1_reg <= link.cmd_data;
      data_s2_reg <= data_s1_reg;
    end
  end

  // code and data are set by the host one cycle before the toggle moves
  assign cmd_evt = tgl_s2_reg ^ tgl_s3_reg;

  ////////////////////////////////////////////////////////////////////////////
  // state, configuration and clock phase
  rcoc_state_e                   state_reg;
  rcoc_state_e                   state_next;
  logic [11:0]                   cfg_reg;
  logic [11:0]                   cfg_next;
  logic [11:0]                   aux_reg;
  logic [11:0]                   aux_next;
  logic                          phase_reg;
  logic                          phase_next;
  logic [rcoc_pkg::CNT_W-1:0]    start_cnt_reg;
  logic [rcoc_pkg::CNT_W-1:0]    start_cnt_next;
  logic [DW-1:0]                 dq_reg;
  logic [DW-1:0]                 dq_next;
  logic [1:0]                    mode;
  logic [1:0]                    new_mode;

  localparam logic [rcoc_pkg::CNT_W-1:0] ON_START =
    rcoc_pkg::CNT_W'(rcoc_pkg::ON_START_CYC);

  assign mode     = cfg_reg[rcoc_pkg::MODE_LSB +: 2];
  assign new_mode = data_s2_reg[rcoc_pkg::MODE_LSB +: 2];

  // next-state logic: commands, start/stop and toggling
  always_comb begin
    state_next     = state_reg;
    cfg_next       = cfg_reg;
    aux_next       = aux_reg;
    phase_next     = phase_reg;
    start_cnt_next = start_cnt_reg;
    dq_next        = dq_reg;
    if (cmd_evt) begin
      case (code_s2_reg)
        rcoc_pkg::RCOC_CMD_CFG_WR: begin
          cfg_next = data_s2_reg;
          case (new_mode)
            rcoc_pkg::RCOC_MODE_OFF: begin
              state_next = RCOC_ST_OFF;
            end
            rcoc_pkg::RCOC_MODE_ON: begin
              // pins stay undriven briefly, then free-run
              state_next     = RCOC_ST_IDLE;
              start_cnt_next = ON_START;
            end
            default: begin
              state_next = RCOC_ST_IDLE;
            end
          endcase
        end
        rcoc_pkg::RCOC_CMD_AUX_WR: begin
          aux_next = data_s2_reg;
        end
        rcoc_pkg::RCOC_CMD_BEGIN: begin
          // only the begin-start mode answers; ignored elsewhere
          if (mode == rcoc_pkg::RCOC_MODE_BEGIN &&
              state_reg == RCOC_ST_IDLE) begin
            state_next = RCOC_ST_RUN;
          end
        end
        rcoc_pkg::RCOC_CMD_HALT: begin
          if ((mode == rcoc_pkg::RCOC_MODE_READ ||
               mode == rcoc_pkg::RCOC_MODE_BEGIN) &&
              state_reg == RCOC_ST_RUN) begin
            state_next = RCOC_ST_STOP;
          end
        end
        default: begin
          // a read of any kind starts the clock in read-start mode
          if (rcoc_pkg::is_read(code_s2_reg) &&
              mode == rcoc_pkg::RCOC_MODE_READ &&
              state_reg == RCOC_ST_IDLE) begin
            state_next = RCOC_ST_RUN;
          end
        end
      endcase
    end else begin
      case (state_reg)
        RCOC_ST_IDLE: begin
          if (start_cnt_reg != '0) begin
            start_cnt_next = start_cnt_reg - 1'b1;
            if (start_cnt_next == '0 && mode == rcoc_pkg::RCOC_MODE_ON) begin
              state_next = RCOC_ST_RUN;
            end
          end
        end
        RCOC_ST_STOP: begin
          // finish on a low phase so the last pulse is whole
          if (!phase_reg) begin
            state_next = RCOC_ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
    // one phase flip per clock: edges and data symbols move together
    if (state_reg == RCOC_ST_RUN ||
        (state_reg == RCOC_ST_STOP && phase_reg)) begin
      phase_next = ~phase_reg;
      dq_next    = rd_data_i;
    end else begin
      phase_next = 1'b0;
    end
  end

  // state registers; disabled is the reset mode
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg     <= RCOC_ST_OFF;
      cfg_reg       <= rcoc_pkg::CFG_RESET;
      aux_reg       <= rcoc_pkg::AUX_RESET;
      phase_reg     <= 1'b0;
      start_cnt_reg <= '0;
      dq_reg        <= '0;
    end else begin
      state_reg     <= state_next;
      cfg_reg       <= cfg_next;
      aux_reg       <= aux_next;
      phase_reg     <= phase_next;
      start_cnt_reg <= start_cnt_next;
      dq_reg        <= dq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: enables are low while driving
  logic driving;
  logic single_ended;

  assign driving      = (state_reg == RCOC_ST_RUN) ||
                        (state_reg == RCOC_ST_STOP);
  assign single_ended = cfg_reg[rcoc_pkg::WIRING_BIT];

  assign link.read_clock_true      = phase_reg;
  assign link.read_clock_comp      = ~phase_reg;
  assign link.read_clock_true_oe_b = ~driving;
  // single-ended leaves the complement undriven at all times
  assign link.read_clock_comp_oe_b = ~driving | single_ended;
  // two-level signalling forces full swing whatever the bit says
  assign link.read_clock_half_swing =
    three_level_i & cfg_reg[rcoc_pkg::SWING_BIT];
  assign link.dq = dq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // user-side status
  assign rd_ready_o = state_reg == RCOC_ST_RUN;
  assign mode_o     = mode;
  assign running_o  = driving;
  assign aux_o      = aux_reg;

endmodule

// file: logic/rcoc_host.sv
`timescale 1ns/1ps
module rcoc_host #(
  parameter int unsigned DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          req_valid_i,
  input  wire logic [3:0]    req_cmd_i,
  input  wire logic [11:0]   req_data_i,
  output logic               req_ready_o,
  output logic               refused_o,
  output logic               clock_active_o,
  output logic [DW-1:0]      rd_data_o,
  output logic               rd_valid_o,
  rcoc_link_if.host          link
);

  ////////////////////////////////////////////////////////////////////////////
  // command issue and the host's own obligations
  logic [11:0]                cfg_reg;
  logic [11:0]                cfg_next;
  logic [11:0]                aux_reg;
  logic [11:0]                aux_next;
  logic                       run_reg;
  logic                       run_next;
  logic [rcoc_pkg::CNT_W-1:0] busy_reg;
  logic [rcoc_pkg::CNT_W-1:0] busy_next;
  logic [3:0]                 code_reg;
  logic [3:0]                 code_next;
  logic [11:0]                data_reg;
  logic [11:0]                data_next;
  logic                       pend_reg;
  logic                       pend_next;
  logic                       tgl_reg;
  logic                       tgl_next;
  logic                       refused_reg;
  logic                       refused_next;
  logic                       legal;
  logic [1:0]                 mode;
  logic [1:0]                 req_mode;

  localparam logic [rcoc_pkg::CNT_W-1:0] GAP =
    rcoc_pkg::CNT_W'(rcoc_pkg::CMD_GAP_CYC);
  localparam logic [rcoc_pkg::CNT_W-1:0] SETTLE =
    rcoc_pkg::CNT_W'(rcoc_pkg::SETTLE_CYC + rcoc_pkg::CMD_GAP_CYC);
  localparam logic [rcoc_pkg::CNT_W-1:0] HALT_WAIT =
    rcoc_pkg::CNT_W'(rcoc_pkg::HALT_WAIT_CYC + rcoc_pkg::CMD_GAP_CYC);
  localparam logic [rcoc_pkg::CNT_W-1:0] BEGIN_HALT_WAIT =
    rcoc_pkg::CNT_W'(rcoc_pkg::BEGIN_HALT_WAIT_CYC + rcoc_pkg::CMD_GAP_CYC);

  assign mode        = cfg_reg[rcoc_pkg::MODE_LSB +: 2];
  assign req_mode    = req_data_i[rcoc_pkg::MODE_LSB +: 2];
  assign req_ready_o = (busy_reg == '0) && !pend_reg;

  // legality of the offered request against the shadowed device state
  always_comb begin
    legal = 1'b1;
    case (req_cmd_i)
      rcoc_pkg::RCOC_CMD_CFG_WR: begin
        if (run_reg) begin
          legal = 1'b0;
        end else if (mode != rcoc_pkg::RCOC_MODE_OFF &&
                     req_mode != rcoc_pkg::RCOC_MODE_OFF &&
                     req_mode != mode) begin
          legal = 1'b0;
        end else if (mode == rcoc_pkg::RCOC_MODE_ON &&
                     req_data_i[11:rcoc_pkg::LOCK_LSB] !=
                     cfg_reg[11:rcoc_pkg::LOCK_LSB]) begin
          legal = 1'b0;
        end
      end
      rcoc_pkg::RCOC_CMD_AUX_WR: begin
        if (run_reg) begin
          legal = 1'b0;
        end else if (mode == rcoc_pkg::RCOC_MODE_ON &&
                     req_data_i[11:rcoc_pkg::AUX_LOCK_LSB] !=
                     aux_reg[11:rcoc_pkg::AUX_LOCK_LSB]) begin
          legal = 1'b0;
        end
      end
      rcoc_pkg::RCOC_CMD_BEGIN: begin
        legal = mode == rcoc_pkg::RCOC_MODE_BEGIN;
      end
      rcoc_pkg::RCOC_CMD_HALT: begin
        legal = run_reg;
      end
      rcoc_pkg::RCOC_CMD_NOP: begin
        legal = 1'b0;
      end
      default: begin
        legal = rcoc_pkg::is_read(req_cmd_i);
      end
    endcase
  end

  // next values: code and data are set one cycle before the toggle
  always_comb begin
    cfg_next     = cfg_reg;
    aux_next     = aux_reg;
    run_next     = run_reg;
    busy_next    = (busy_reg != '0) ? busy_reg - 1'b1 : busy_reg;
    code_next    = code_reg;
    data_next    = data_reg;
    pend_next    = 1'b0;
    tgl_next     = pend_reg ? ~tgl_reg : tgl_reg;
    refused_next = 1'b0;
    if (req_valid_i && req_ready_o) begin
      if (!legal) begin
        refused_next = 1'b1;
      end else begin
        code_next = req_cmd_i;
        data_next = req_data_i;
        pend_next = 1'b1;
        busy_next = GAP;
        case (req_cmd_i)
          rcoc_pkg::RCOC_CMD_CFG_WR: begin
            cfg_next  = req_data_i;
            busy_next = SETTLE;
          end
          rcoc_pkg::RCOC_CMD_AUX_WR: begin
            aux_next  = req_data_i;
            busy_next = SETTLE;
          end
          rcoc_pkg::RCOC_CMD_BEGIN: begin
            run_next = 1'b1;
          end
          rcoc_pkg::RCOC_CMD_HALT: begin
            run_next  = 1'b0;
            busy_next = (mode == rcoc_pkg::RCOC_MODE_BEGIN) ?
                        BEGIN_HALT_WAIT : HALT_WAIT;
          end
          default: begin
            if (mode == rcoc_pkg::RCOC_MODE_READ) begin
              run_next = 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cfg_reg     <= rcoc_pkg::CFG_RESET;
      aux_reg     <= rcoc_pkg::AUX_RESET;
      run_reg     <= 1'b0;
      busy_reg    <= '0;
      code_reg    <= 4'h0;
      data_reg    <= 12'h000;
      pend_reg    <= 1'b0;
      tgl_reg     <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      cfg_reg     <= cfg_next;
      aux_reg     <= aux_next;
      run_reg     <= run_next;
      busy_reg    <= busy_next;
      code_reg    <= code_next;
      data_reg    <= data_next;
      pend_reg    <= pend_next;
      tgl_reg     <= tgl_next;
      refused_reg <= refused_next;
    end
  end

  assign link.cmd_code = code_reg;
  assign link.cmd_data = data_reg;
  assign link.cmd_tgl  = tgl_reg;
  assign refused_o     = refused_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read capture: pins pass two flops, then rising edges latch data
  logic          rck_s1_reg;
  logic          rck_s2_reg;
  logic          rck_s3_reg;
  logic          oe_s1_reg;
  logic          oe_s2_reg;
  logic [DW-1:0] dq_s1_reg;
  logic [DW-1:0] dq_s2_reg;
  logic [DW-1:0] rd_data_reg;
  logic          rd_valid_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rck_s1_reg   <= 1'b0;
      rck_s2_reg   <= 1'b0;
      rck_s3_reg   <= 1'b0;
      oe_s1_reg    <= 1'b1;
      oe_s2_reg    <= 1'b1;
      dq_s1_reg    <= '0;
      dq_s2_reg    <= '0;
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      rck_s1_reg   <= link.read_clock_true;
      rck_s2_reg   <= rck_s1_reg;
      rck_s3_reg   <= rck_s2_reg;
      oe_s1_reg    <= link.read_clock_true_oe_b;
      oe_s2_reg    <= oe_s1_reg;
      dq_s1_reg    <= link.dq;
      dq_s2_reg    <= dq_s1_reg;
      // a slow model capture: data changes with the edge, so the
      // synced copy is taken together with the synced edge
      rd_valid_reg <= !oe_s2_reg && rck_s2_reg && !rck_s3_reg;
      if (!oe_s2_reg && rck_s2_reg && !rck_s3_reg) begin
        rd_data_reg <= dq_s2_reg;
      end
    end
  end

  assign clock_active_o = ~oe_s2_reg;
  assign rd_data_o      = rd_data_reg;
  assign rd_valid_o     = rd_valid_reg;

endmodule

// file: verification/rcoc_chk.sv
`timescale 1ns/1ps
module rcoc_chk #(
  parameter int unsigned DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic [3:0]    cmd_code,
  input  wire logic [11:0]   cmd_data,
  input  wire logic          cmd_tgl,
  input  wire logic          read_clock_true,
  input  wire logic          read_clock_true_oe_b,
  input  wire logic          read_clock_comp,
  input  wire logic          read_clock_comp_oe_b,
  input  wire logic [DW-1:0] dq
);
  logic       tgl_reg;
  logic       tgl_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic       wiring_reg;
  logic       wiring_next;
  logic       ev;
  logic       rd_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // shadow of the accepted configuration, seen from the command toggles
  assign ev = cmd_tgl != tgl_reg;
  assign rd_cmd = rcoc_pkg::is_read(cmd_code);

  // refused requests never toggle, so only accepted writes land here
  always_comb begin
    tgl_next = cmd_tgl;
    mode_next = mode_reg;
    wiring_next = wiring_reg;
    if (ev && cmd_code == rcoc_pkg::RCOC_CMD_CFG_WR) begin
      mode_next = cmd_data[1:0];
      wiring_next = cmd_data[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      tgl_reg <= 1'b0;
      mode_reg <= 2'b00;
      wiring_reg <= 1'b0;
    end else begin
      tgl_reg <= tgl_next;
      mode_reg <= mode_next;
      wiring_reg <= wiring_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_off;
    read_clock_true_oe_b && read_clock_comp_oe_b;
  endsequence
  sequence s_on;
    !read_clock_true_oe_b;
  endsequence
  sequence s_cmd(c);
    ev && cmd_code == c;
  endsequence

  property p_comp_inv;
    !read_clock_comp_oe_b |-> read_clock_comp == !read_clock_true;
  endproperty
  a_comp_inv: assert property (p_comp_inv)
    else $error("complement pin not inverse of true pin");

  property p_dq_edge;
    !read_clock_true_oe_b && $changed(dq) |-> $changed(read_clock_true);
  endproperty
  a_dq_edge: assert property (p_dq_edge)
    else $error("data lanes changed without a clock edge");

  property p_wiring;
    !read_clock_true_oe_b |-> read_clock_comp_oe_b == wiring_reg;
  endproperty
  a_wiring: assert property (p_wiring)
    else $error("complement drive does not match wiring select");

  property p_both_off;
    read_clock_true_oe_b |-> read_clock_comp_oe_b;
  endproperty
  a_both_off: assert property (p_both_off)
    else $error("complement driven while true pin undriven");

  property p_high_one;
    !read_clock_true_oe_b && read_clock_true
      |=> !read_clock_true || read_clock_true_oe_b;
  endproperty
  a_high_one: assert property (p_high_one)
    else $error("read clock high for more than one cycle");

  property p_off_write;
    s_cmd(rcoc_pkg::RCOC_CMD_CFG_WR) ##0 cmd_data[1:0] == 2'b00
      |-> ##[1:8] s_off;
  endproperty
  a_off_write: assert property (p_off_write)
    else $error("pins not released after disabling write");

  property p_on_start;
    s_cmd(rcoc_pkg::RCOC_CMD_CFG_WR) ##0 cmd_data[1:0] == 2'b11
      |-> ##[1:8] s_on;
  endproperty
  a_on_start: assert property (p_on_start)
    else $error("always-on clock did not start in time");

  property p_read_start;
    s_cmd(cmd_code) ##0 rd_cmd && mode_reg == 2'b01 && read_clock_true_oe_b
      |-> ##[1:6] s_on;
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("read did not start the clock");

  property p_read_ignored;
    s_cmd(cmd_code) ##0 rd_cmd && mode_reg == 2'b10 && read_clock_true_oe_b
      |=> read_clock_true_oe_b [*6];
  endproperty
  a_read_ignored: assert property (p_read_ignored)
    else $error("read started the clock in begin mode");

  property p_begin_start;
    s_cmd(rcoc_pkg::RCOC_CMD_BEGIN) ##0 mode_reg == 2'b10
      |-> ##[1:6] s_on;
  endproperty
  a_begin_start: assert property (p_begin_start)
    else $error("begin did not start the clock");

  property p_halt_stop;
    s_cmd(rcoc_pkg::RCOC_CMD_HALT) ##0 !read_clock_true_oe_b
      |-> ##[1:10] s_off;
  endproperty
  a_halt_stop: assert property (p_halt_stop)
    else $error("halt did not release the pins");
endmodule

// file: verification/test_read_clock_output_control.sv
`timescale 1ns/1ps
module test_read_clock_output_control;
  logic        clk;
  logic        rst_b;
  logic        req_valid;
  logic [3:0]  req_cmd;
  logic [11:0] req_data;
  logic        three_level;
  logic [7:0]  rd_data = 8'h00;
  logic        req_ready;
  logic        rd_ready;
  logic        rd_valid;
  logic        refused;
  logic        clock_active;
  logic [1:0]  mode;
  logic        running;
  logic [11:0] aux;
  int          fails;
  int          tests_run;
  logic [3:0]  rd_codes [5] = '{4'h3, 4'h6, 4'h7, 4'h8, 4'h9};

  rcoc_link_if #(.DW(8)) rcoc_link_if_i ();
  rcoc_device #(.DW(8)) rcoc_device_i (
    .clk_i(clk), .rst_b_i(rst_b), .three_level_i(three_level),
    .rd_data_i(rd_data), .rd_ready_o(rd_ready), .mode_o(mode),
    .running_o(running), .aux_o(aux), .link(rcoc_link_if_i));
  rcoc_host #(.DW(8)) rcoc_host_i (
    .clk_i(clk), .rst_b_i(rst_b), .req_valid_i(req_valid),
    .req_cmd_i(req_cmd), .req_data_i(req_data), .req_ready_o(req_ready),
    .refused_o(refused), .clock_active_o(clock_active), .rd_data_o(),
    .rd_valid_o(rd_valid), .link(rcoc_link_if_i));
  rcoc_chk #(.DW(8)) rcoc_chk_i (
    .clk_i(clk), .rst_b_i(rst_b), .cmd_code(rcoc_link_if_i.cmd_code),
    .cmd_data(rcoc_link_if_i.cmd_data), .cmd_tgl(rcoc_link_if_i.cmd_tgl),
    .read_clock_true(rcoc_link_if_i.read_clock_true),
    .read_clock_true_oe_b(rcoc_link_if_i.read_clock_true_oe_b),
    .read_clock_comp(rcoc_link_if_i.read_clock_comp),
    .read_clock_comp_oe_b(rcoc_link_if_i.read_clock_comp_oe_b),
    .dq(rcoc_link_if_i.dq));

  ////////////////////////////////////////////////////////////////////////////
  // clock, and read data that changes every cycle
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) rd_data <= rd_data + 8'h01;

  task automatic end_of_test();
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [11:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", name, e, g);
      fails++;
    end
  endtask
  task automatic chkb(input string name, input logic e, g);
    chk(name, {11'h000, e}, {11'h000, g});
  endtask
  task automatic pins(input logic t, c);
    chkb("true_oe_b", t, rcoc_link_if_i.read_clock_true_oe_b);
    chkb("comp_oe_b", c, rcoc_link_if_i.read_clock_comp_oe_b);
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // hold the request until ready is seen high at an edge, then judge it
  task automatic send(input logic [3:0] c, input logic [11:0] d,
                      input logic rf);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_data <= d;
    do begin
      @(negedge clk);
      n++;
      if (n > 300) begin
        fails++;
        end_of_test();
      end
    end while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chkb("refused", rf, refused);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    pins(1'b1, 1'b1);
    chk("mode", 12'h000, {10'h000, mode});
    send(rcoc_pkg::RCOC_CMD_AUX_WR, 12'h400, 1'b0);
    idle(10);
    chk("aux", 12'h400, aux);
  endtask

  task automatic t_always_on();
    int n;
    logic p;
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h00b, 1'b0);
    idle(10);
    pins(1'b0, 1'b0);
    chkb("half", 1'b0, rcoc_link_if_i.read_clock_half_swing);
    chk("mode", 12'h003, {10'h000, mode});
    n = 0;
    p = rcoc_link_if_i.read_clock_true;
    repeat (8) begin
      @(negedge clk);
      if (rcoc_link_if_i.read_clock_true !== p) n++;
      n += int'(rd_valid);
      p = rcoc_link_if_i.read_clock_true;
    end
    chk("toggles", 12'h00c, 12'(n));
    chkb("active", 1'b1, clock_active);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h003, 1'b1);
    send(rcoc_pkg::RCOC_CMD_AUX_WR, 12'h000, 1'b1);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h00a, 1'b1);
    send(rcoc_pkg::RCOC_CMD_BEGIN, 12'h000, 1'b1);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h008, 1'b0);
    idle(10);
    pins(1'b1, 1'b1);
  endtask

  // swing select only matters with three-level signalling
  task automatic t_swing();
    @(posedge clk) three_level <= 1'b1;
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h00b, 1'b0);
    idle(10);
    chkb("half", 1'b1, rcoc_link_if_i.read_clock_half_swing);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h008, 1'b0);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h003, 1'b0);
    idle(10);
    chkb("half", 1'b0, rcoc_link_if_i.read_clock_half_swing);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h000, 1'b0);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h007, 1'b0);
    idle(10);
    pins(1'b0, 1'b1);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h004, 1'b0);
  endtask

  task automatic t_read_mode();
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h001, 1'b0);
    send(rcoc_pkg::RCOC_CMD_BEGIN, 12'h000, 1'b1);
    pins(1'b1, 1'b1);
    foreach (rd_codes[i]) begin
      send(rd_codes[i], 12'h000, 1'b0);
      idle(8);
      pins(1'b0, 1'b0);
      chkb("running", 1'b1, running);
      chkb("rd_ready", 1'b1, rd_ready);
      send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h000, 1'b1);
      send(rcoc_pkg::RCOC_CMD_HALT, 12'h000, 1'b0);
      idle(10);
      pins(1'b1, 1'b1);
    end
  endtask

  task automatic t_begin_mode();
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h002, 1'b1);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h000, 1'b0);
    send(rcoc_pkg::RCOC_CMD_CFG_WR, 12'h002, 1'b0);
    send(rcoc_pkg::RCOC_CMD_READ, 12'h000, 1'b0);
    idle(8);
    pins(1'b1, 1'b1);
    send(rcoc_pkg::RCOC_CMD_BEGIN, 12'h000, 1'b0);
    idle(8);
    pins(1'b0, 1'b0);
    send(rcoc_pkg::RCOC_CMD_AUX_WR, 12'h000, 1'b1);
    send(rcoc_pkg::RCOC_CMD_HALT, 12'h000, 1'b0);
    idle(10);
    pins(1'b1, 1'b1);
    send(rcoc_pkg::RCOC_CMD_HALT, 12'h000, 1'b1);
    send(rcoc_pkg::RCOC_CMD_NOP, 12'h000, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_cmd = 4'h0;
    req_data = 12'h000;
    three_level = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    t_reset();
    t_always_on();
    t_swing();
    t_read_mode();
    t_begin_mode();
    end_of_test();
  end
endmodule
